// [mie_map.vh]
`ifndef MIE_MAP_VH
`define MIE_MAP_VH
// Operation codes presented on op_code (block-local encoding)
`define MIE_OP_IDLE        6'h00
`define MIE_OP_ADC_A       6'h01
`define MIE_OP_ADC_M       6'h02
`define MIE_OP_ADD_A       6'h03
`define MIE_OP_ADD_X       6'h04
`define MIE_OP_ADD_M       6'h05
`define MIE_OP_AND_A       6'h06
`define MIE_OP_AND_X       6'h07
`define MIE_OP_AND_M       6'h08
`define MIE_OP_OR_A        6'h09
`define MIE_OP_OR_X        6'h0a
`define MIE_OP_OR_M        6'h0b
`define MIE_OP_CALL        6'h0c
`define MIE_OP_BRANCH      6'h0d
`define MIE_OP_RET         6'h0e
`define MIE_OP_RET_X       6'h0f
`define MIE_OP_INTERRUPT_EXIT        6'h10
`define MIE_OP_ZFILL       6'h11
`define MIE_OP_ZFILL_BIT   6'h12
`define MIE_OP_WDT_KICK    6'h13
`define MIE_OP_WDT_PRE1    6'h14
`define MIE_OP_WDT_PRE2    6'h15
`define MIE_OP_CPL_M       6'h16
`define MIE_OP_CPL_A       6'h17
`define MIE_OP_DAA         6'h18
`define MIE_OP_DEC_M       6'h19
`define MIE_OP_DEC_A       6'h1a
`define MIE_OP_INC_M       6'h1b
`define MIE_OP_INC_A       6'h1c
`define MIE_OP_PDOWN       6'h1d
`define MIE_OP_MOV_AM      6'h1e
`define MIE_OP_MOV_AX      6'h1f
`define MIE_OP_MOV_MA      6'h20
`define MIE_OP_RL_M        6'h21
`define MIE_OP_RL_A        6'h22
`define MIE_OP_PCL_WR      6'h23
// Reset values
`define MIE_ACC_RST        8'h00
`define MIE_PC_RST         13'h0000
// Constants used by operations
`define MIE_ONE_B          8'h01
`define MIE_ZERO_B         8'h00
`define MIE_ADJ_NIB        4'h6
`define MIE_NIB_MAX        4'h9
// Pre-kick history codes
`define MIE_PK_NONE        2'h0
`define MIE_PK_FIRST       2'h1
`define MIE_PK_SECOND      2'h2
`endif

// [mie_core.v]
//Contract
//- Add with carry to acc or ram
//- Add without carry, memory or immediate
//- AND to acc or ram, zero only
//- OR to acc or ram, zero only
//- Call pushes pc plus one, two cycles
//- Branch loads target, two cycles
//- Return pops pc, optional acc load
//- Interrupt return pops pc, enables irq
//- Clear byte or single bit, no flags
//- Watchdog kick clears counter and flags
//- Pre-kicks work only when alternated
//- Complement in place or to acc
//- Decimal adjust acc into ram, carry only
//- Decrement in place or to acc
//- Increment in place or to acc
//- Power down stops, flags set/clear
//- Moves change no flag
//- Idle only advances the pc
//- Rotate left ram, no flags
//- Rotate left into acc, ram kept
//- Writing pc low byte takes two cycles
//- Pre-kick pair clears expiry and sleep flags
`include "mie_map.vh"
module mie_core (
   input  wire        clk,          // System clock
   input  wire        rstn,         // Async reset, active low
   input  wire        op_valid,     // Instruction present this cycle
   input  wire [5:0]  op_code,      // Decoded operation
   input  wire [7:0]  op_imm,       // Immediate operand
   input  wire [12:0] op_addr,      // Branch or call target
   input  wire [2:0]  op_bit,       // Bit select
   input  wire [7:0]  mem_rdata,    // Addressed data byte
   input  wire [12:0] stack_top,    // Top of return stack
   input  wire        irq_pending,  // Interrupt waiting
   input  wire        wake,         // Wake from power down
   output wire        op_ready,     // Can accept instruction
   output reg  [7:0]  mem_wdata,    // Data byte to write
   output reg         mem_we,       // Data write pulse
   output reg         stack_push,   // Push pulse
   output reg  [12:0] stack_wdata,  // Pushed address
   output reg         stack_pop,    // Pop pulse
   output reg  [7:0]  acc,          // Accumulator
   output reg  [12:0] pc,           // Program counter
   output reg         flag_c,       // Carry
   output reg         flag_ac,      // Half carry
   output reg         flag_z,       // Zero
   output reg         flag_ov,      // Signed overflow
   output reg         flag_to,      // Watchdog expiry
   output reg         flag_pdf,     // Sleep entered
   output reg         irq_en,       // Global interrupt enable
   output reg         irq_take,     // Pending irq to be serviced
   output reg         wdt_clear,    // Watchdog and prescaler clear
   output reg         sys_clk_off   // Sleeping, clock stopped
);

   ////////////////////////////////////////////////////////////////////
   // State
   // dummy_r marks the refetch cycle after a pc reload.
   // pk_r remembers the last lone pre-kick, if any.
   // sleep_r holds the core in power down until wake.
   // None of them is visible at the ports except through
   // op_ready and the flags.
   reg        dummy_r;              // Second cycle of a two-cycle op
   reg [1:0]  pk_r;                 // Last pre-kick seen
   reg        sleep_r;              // Power-down state

   // Handshake: the source offers one op with op_valid and
   // it is taken on the edge where op_ready is also high.
   // Results show on the outputs just after that edge.
   // op_ready is combinational so the source can stall
   // without a cycle of latency; the price is a path from
   // dummy_r and sleep_r straight to the port.
   // Ops that reload the pc leave dummy_r set for one cycle,
   // standing in for the refetch of the new target.
   // While asleep nothing is taken; only wake is watched.
   // Offering an op while op_ready is low has no effect.
   //
   // Two-cycle ops hold off the next fetch; sleep also stalls
   assign op_ready = ~dummy_r & ~sleep_r;

   ////////////////////////////////////////////////////////////////////
   // Arithmetic helpers
   // The adder is shared by all sum forms; carry-in is forced
   // low except for the carry-using forms.
   // Flags are worked out from the same operands as the sum
   // so that half carry and overflow never disagree with it.
   // Overflow is judged on the sign bits only: same-sign
   // operands giving a result of the other sign.
   //
   // 9-bit add with carry-in; returns {c,sum}
   function [8:0] add9;
      input [7:0] a;
      input [7:0] b;
      input       ci;
      begin
         add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      end
   endfunction

   // Half carry out of bit 3
   function hcarry;
      input [7:0] a;
      input [7:0] b;
      input       ci;
      reg   [4:0] t;
      begin
         t = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
         hcarry = t[4];
      end
   endfunction

   // Two's-complement overflow
   function ovf;
      input [7:0] a;
      input [7:0] b;
      input [7:0] s;
      begin
         ovf = (a[7] == b[7]) && (s[7] != a[7]);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Execute combinational
   // Everything here is a pure function of the current op,
   // the operand byte and the held acc and flags.
   // opb picks the immediate only for the immediate sum form;
   // all other sums read the addressed byte.
   // The decimal adjust looks at acc and at the half carry and
   // carry left by the previous sum, not at the byte read.
   // Its carry is sticky: once set it is never cleared here,
   // which lets multi-byte decimal sums chain.
   // lres covers the logic and unary forms; unused ops see
   // zero so the case never leaves a latch behind.
   // Unary forms read the byte, never acc.
   reg [7:0]  opb;                  // Second add operand
   reg        cin;                  // Carry in
   reg [8:0]  sum;                  // Adder result
   reg [7:0]  lres;                 // Logic/unary result
   reg [7:0]  daa_v;                // Adjustment addend
   reg        daa_c;                // Adjusted carry
   reg [8:0]  daa_s;                // Adjust sum

   always @* begin
      opb = (op_code == `MIE_OP_ADD_X) ? op_imm : mem_rdata;
      cin = ((op_code == `MIE_OP_ADC_A) || (op_code == `MIE_OP_ADC_M)) ? flag_c : 1'b0;
      sum = add9(acc, opb, cin);
      daa_v = `MIE_ZERO_B;
      if ((acc[3:0] > `MIE_NIB_MAX) || flag_ac) begin
         daa_v[3:0] = `MIE_ADJ_NIB;
      end
      if ((acc[7:4] > `MIE_NIB_MAX) || flag_c) begin
         daa_v[7:4] = `MIE_ADJ_NIB;
      end
      daa_s = {1'b0, acc} + {1'b0, daa_v};
      daa_c = flag_c | daa_s[8];
      case (op_code)
         `MIE_OP_AND_A, `MIE_OP_AND_M: lres = acc & mem_rdata;
         `MIE_OP_AND_X:               lres = acc & op_imm;
         `MIE_OP_OR_A, `MIE_OP_OR_M:  lres = acc | mem_rdata;
         `MIE_OP_OR_X:                lres = acc | op_imm;
         `MIE_OP_CPL_M, `MIE_OP_CPL_A: lres = ~mem_rdata;
         `MIE_OP_DEC_M, `MIE_OP_DEC_A: lres = mem_rdata - `MIE_ONE_B;
         `MIE_OP_INC_M, `MIE_OP_INC_A: lres = mem_rdata + `MIE_ONE_B;
         `MIE_OP_RL_M, `MIE_OP_RL_A:  lres = {mem_rdata[6:0], mem_rdata[7]};
         default:                     lres = `MIE_ZERO_B;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Sequential execute
   // One op is taken per accepted edge. The pc moves on by
   // one for every taken op and is then overwritten by the
   // forms that load it, so the last assignment wins.
   // Pulse outputs drop to low every cycle unless an op
   // raises them again, so each stands for one cycle only.
   // The pre-kick history is dropped by any other op taken,
   // which keeps a stray pair split by other code from acting.
   // Power down sets sleep_r; from then on only wake counts
   // and all registers but the pulses keep their contents.
   // Reset clears every register, so op_ready is high at
   // the first edge after release.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc <= `MIE_ACC_RST;
         pc <= `MIE_PC_RST;
         flag_c <= 1'b0;
         flag_ac <= 1'b0;
         flag_z <= 1'b0;
         flag_ov <= 1'b0;
         flag_to <= 1'b0;
         flag_pdf <= 1'b0;
         irq_en <= 1'b0;
         irq_take <= 1'b0;
         wdt_clear <= 1'b0;
         sys_clk_off <= 1'b0;
         mem_wdata <= `MIE_ZERO_B;
         mem_we <= 1'b0;
         stack_push <= 1'b0;
         stack_wdata <= `MIE_PC_RST;
         stack_pop <= 1'b0;
         dummy_r <= 1'b0;
         pk_r <= `MIE_PK_NONE;
         sleep_r <= 1'b0;
      end else begin
         // Default each cycle: clear the pulses and the
         // dummy flag; branches below set them again.
         // A dummy cycle ignores op_valid entirely.
         // Pulses default low
         mem_we <= 1'b0;
         stack_push <= 1'b0;
         stack_pop <= 1'b0;
         wdt_clear <= 1'b0;
         irq_take <= 1'b0;
         dummy_r <= 1'b0;
         if (sleep_r) begin
            // Contents retained until wake
            if (wake) begin
               sleep_r <= 1'b0;
               sys_clk_off <= 1'b0;
            end
         end else if (op_valid && !dummy_r) begin
            pc <= pc + 13'h0001;
            // Any other op breaks the pre-kick alternation
            if ((op_code != `MIE_OP_WDT_PRE1) && (op_code != `MIE_OP_WDT_PRE2)) begin
               pk_r <= `MIE_PK_NONE;
            end
            case (op_code)
               `MIE_OP_ADC_A, `MIE_OP_ADD_A, `MIE_OP_ADD_X,
               `MIE_OP_ADC_M, `MIE_OP_ADD_M: begin
                  if ((op_code == `MIE_OP_ADC_M) || (op_code == `MIE_OP_ADD_M)) begin
                     mem_wdata <= sum[7:0];
                     mem_we <= 1'b1;
                  end else begin
                     acc <= sum[7:0];
                  end
                  flag_c <= sum[8];
                  flag_ac <= hcarry(acc, opb, cin);
                  flag_z <= (sum[7:0] == `MIE_ZERO_B);
                  flag_ov <= ovf(acc, opb, sum[7:0]);
               end
               // Acc forms: result to acc, only zero changes.
               // Memory forms below write the byte instead and
               // leave acc alone.
               `MIE_OP_AND_A, `MIE_OP_AND_X, `MIE_OP_OR_A, `MIE_OP_OR_X,
               `MIE_OP_CPL_A, `MIE_OP_DEC_A, `MIE_OP_INC_A: begin
                  acc <= lres;
                  flag_z <= (lres == `MIE_ZERO_B);
               end
               `MIE_OP_AND_M, `MIE_OP_OR_M, `MIE_OP_CPL_M,
               `MIE_OP_DEC_M, `MIE_OP_INC_M: begin
                  mem_wdata <= lres;
                  mem_we <= 1'b1;
                  flag_z <= (lres == `MIE_ZERO_B);
               end
               `MIE_OP_RL_M: begin
                  mem_wdata <= lres;
                  mem_we <= 1'b1;
               end
               `MIE_OP_RL_A: begin
                  acc <= lres;
               end
               // Call: return address is the pc after this op.
               // The push and the jump share one edge; the stack
               // side stores stack_wdata on the following edge.
               `MIE_OP_CALL: begin
                  stack_wdata <= pc + 13'h0001;
                  stack_push <= 1'b1;
                  pc <= op_addr;
                  dummy_r <= 1'b1;
               end
               `MIE_OP_BRANCH: begin
                  pc <= op_addr;
                  dummy_r <= 1'b1;
               end
               // Return: pc from the stack top; the immediate
               // form also loads acc. Two cycles like a branch.
               `MIE_OP_RET, `MIE_OP_RET_X: begin
                  pc <= stack_top;
                  stack_pop <= 1'b1;
                  dummy_r <= 1'b1;
                  if (op_code == `MIE_OP_RET_X) begin
                     acc <= op_imm;
                  end
               end
               // Interrupt return also sets the global enable
               // and flags a pending request for service first.
               `MIE_OP_INTERRUPT_EXIT: begin
                  pc <= stack_top;
                  stack_pop <= 1'b1;
                  irq_en <= 1'b1;
                  irq_take <= irq_pending;                 // Service before main resumes
                  dummy_r <= 1'b1;
               end
               `MIE_OP_ZFILL: begin
                  mem_wdata <= `MIE_ZERO_B;
                  mem_we <= 1'b1;
               end
               // Only the selected bit falls; the rest of the
               // byte is written back as read.
               `MIE_OP_ZFILL_BIT: begin
                  mem_wdata <= mem_rdata & ~(`MIE_ONE_B << op_bit);
                  mem_we <= 1'b1;
               end
               `MIE_OP_WDT_KICK: begin
                  wdt_clear <= 1'b1;
                  flag_to <= 1'b0;
                  flag_pdf <= 1'b0;
               end
               // Pre-kicks: a lone one only records itself.
               // The matched partner clears the watchdog and
               // both flags, then history starts afresh.
               // The same one twice just records it again.
               `MIE_OP_WDT_PRE1, `MIE_OP_WDT_PRE2: begin
                  // Effective only when following the other pre-kick
                  if (((op_code == `MIE_OP_WDT_PRE1) && (pk_r == `MIE_PK_SECOND)) ||
                      ((op_code == `MIE_OP_WDT_PRE2) && (pk_r == `MIE_PK_FIRST))) begin
                     wdt_clear <= 1'b1;
                     flag_to <= 1'b0;
                     flag_pdf <= 1'b0;
                     pk_r <= `MIE_PK_NONE;
                  end else begin
                     pk_r <= (op_code == `MIE_OP_WDT_PRE1) ? `MIE_PK_FIRST : `MIE_PK_SECOND;
                  end
               end
               // Adjusted acc goes to the byte; acc itself kept.
               // Only carry may move, and only upwards.
               `MIE_OP_DAA: begin
                  mem_wdata <= daa_s[7:0];
                  mem_we <= 1'b1;
                  flag_c <= daa_c;
               end
               // Power down: clock off, contents kept, watchdog
               // and prescaler cleared through wdt_clear.
               // Leaves on wake, which the core cannot create.
               `MIE_OP_PDOWN: begin
                  wdt_clear <= 1'b1;
                  flag_pdf <= 1'b1;
                  flag_to <= 1'b0;
                  sleep_r <= 1'b1;
                  sys_clk_off <= 1'b1;
               end
               // Moves never touch a flag.
               // Byte writes pair with the byte just read.
               `MIE_OP_MOV_AM: acc <= mem_rdata;
               `MIE_OP_MOV_AX: acc <= op_imm;
               `MIE_OP_MOV_MA: begin
                  mem_wdata <= acc;
                  mem_we <= 1'b1;
               end
               `MIE_OP_PCL_WR: begin
                  // Store acc to pc low byte, refetch costs a cycle
                  pc <= {pc[12:8], acc};
                  dummy_r <= 1'b1;
               end
               default: begin
                  // Idle: only the pc advances
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Limitations
   // No interrupt controller lives here: irq_take is only a
   // hint that a pending request should be served before the
   // main program resumes; vectoring is left outside the core.
   // The watchdog counter sits outside; wdt_clear drives it.
   // Data and stack storage sit outside too; the stack must
   // present stack_top combinationally for the returns.
   // Data writes use the same address as the read before.
   //
endmodule

// [mie_core_monitor.sv]
`include "mie_map.vh"
module mie_core_monitor (
   input wire        clk,          // Clock
   input wire        rstn,         // Reset, low
   input wire        op_valid,     // Request
   input wire [5:0]  op_code,      // Operation
   input wire [12:0] op_addr,      // Target
   input wire [7:0]  mem_rdata,    // Byte read
   input wire [12:0] stack_top,    // Stack top
   input wire        irq_pending,  // Irq waiting
   input wire        op_ready,     // Accepting
   input wire [7:0]  mem_wdata,    // Byte written
   input wire        mem_we,       // Write pulse
   input wire        stack_push,   // Push pulse
   input wire [12:0] stack_wdata,  // Pushed value
   input wire        stack_pop,    // Pop pulse
   input wire [12:0] pc,           // Program counter
   input wire        flag_to,      // Expiry flag
   input wire        flag_pdf,     // Sleep flag
   input wire        irq_en,       // Irq enable
   input wire        irq_take,     // Irq hint
   input wire        wdt_clear,    // Watchdog clear
   input wire        sys_clk_off   // Sleeping
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire tk = op_valid && op_ready;  // Accepted this edge
   ////////////////////////////////////////////////////////////////////////////
   property p_call; tk && op_code == `MIE_OP_CALL |=> stack_push && !op_ready
      && stack_wdata == $past(pc) + 13'h1 && pc == $past(op_addr); endproperty
   a_call: assert property (p_call) else $error("call push or target wrong");
   // Dummy cycle, then ready again
   property p_branch; tk && op_code == `MIE_OP_BRANCH |=> pc == $past(op_addr)
      && !op_ready ##1 op_ready; endproperty
   a_branch: assert property (p_branch) else $error("branch wrong");
   property p_ret; tk && (op_code == `MIE_OP_RET || op_code == `MIE_OP_RET_X)
      |=> stack_pop && pc == $past(stack_top); endproperty
   a_ret: assert property (p_ret) else $error("return wrong");
   property p_interrupt_exit; tk && op_code == `MIE_OP_INTERRUPT_EXIT |=> irq_en && pc == $past(stack_top)
      && irq_take == $past(irq_pending); endproperty
   a_interrupt_exit: assert property (p_interrupt_exit) else $error("irq return wrong");
   property p_zfill; tk && op_code == `MIE_OP_ZFILL |=> mem_we && mem_wdata == 8'h00;
   endproperty
   a_zfill: assert property (p_zfill) else $error("clear byte wrong");
   property p_kick; tk && op_code == `MIE_OP_WDT_KICK |=> wdt_clear && !flag_to && !flag_pdf;
   endproperty
   a_kick: assert property (p_kick) else $error("kick wrong");
   // Same pre-kick twice, nothing in between: no effect
   property p_pre_rep; tk && op_code == `MIE_OP_WDT_PRE1 ##1 !tk
      ##1 tk && op_code == `MIE_OP_WDT_PRE1 |=> !wdt_clear && $stable(flag_pdf); endproperty
   a_pre_rep: assert property (p_pre_rep) else $error("repeat pre-kick acted");
   property p_pdown; tk && op_code == `MIE_OP_PDOWN |=> sys_clk_off && flag_pdf && !flag_to
      && !op_ready; endproperty
   a_pdown: assert property (p_pdown) else $error("power down wrong");
   property p_rl; tk && op_code == `MIE_OP_RL_M |=> mem_we
      && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}; endproperty
   a_rl: assert property (p_rl) else $error("rotate wrong");
   property p_single; tk && op_code <= `MIE_OP_OR_M |=> op_ready && !stack_pop; endproperty
   a_single: assert property (p_single) else $error("single op stalled");
   ////////////////////////////////////////////////////////////////////////////
   c_call: cover property (tk && op_code == `MIE_OP_CALL);
   c_interrupt_exit: cover property (tk && op_code == `MIE_OP_INTERRUPT_EXIT && irq_pending);
   c_pdown: cover property (tk && op_code == `MIE_OP_PDOWN);
endmodule
bind mie_core mie_core_monitor u_mon (.*);

// [mie_mem_model.sv]
module mie_mem_model (
   input  wire        clk,          // System clock
   input  wire [3:0]  sel,          // Byte chosen by bench
   input  wire        mem_we,       // Write pulse
   input  wire [7:0]  mem_wdata,    // Write byte
   output wire [7:0]  mem_rdata,    // Addressed byte
   input  wire        stack_push,   // Push pulse
   input  wire [12:0] stack_wdata,  // Pushed address
   input  wire        stack_pop,    // Pop pulse
   output wire [12:0] stack_top     // Top entry
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [16];  // Data bytes
   logic [12:0] stk [8];   // Return stack, wraps when overfilled
   logic [2:0]  sp = '0;   // Next free slot
   initial foreach (mem[i]) mem[i] = 8'(i * 37);
   assign mem_rdata = mem[sel];
   assign stack_top = stk[sp - 3'h1];
   // Write byte and move stack on the edge after the pulse
   always @(posedge clk) begin
      if (mem_we) mem[sel] <= mem_wdata;
      if (stack_push) begin
         stk[sp] <= stack_wdata;
         sp <= sp + 3'h1;
      end else if (stack_pop) sp <= sp - 3'h1;
   end
endmodule

// [mie_core_bench.sv]
`include "mie_map.vh"
module mie_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, op_valid = 0, irq_pending = 0, wake = 0;  // Driven inputs
   logic [5:0] op_code = '0;
   logic [7:0] op_imm = '0;
   logic [12:0] op_addr = '0;
   logic [2:0] op_bit = '0;
   logic [3:0] sel = '0;
   wire [7:0] mem_rdata, mem_wdata, acc;
   wire [12:0] stack_top, stack_wdata, pc;
   wire op_ready, mem_we, stack_push, stack_pop, flag_c, flag_ac, flag_z, flag_ov;
   wire flag_to, flag_pdf, irq_en, irq_take, wdt_clear, sys_clk_off;
   int error_cnt = 0, compares = 0, cyc = 0, ms = 0;
   int m_acc = 0, m_pc = 0, m_c = 0, m_ac = 0, m_z = 0, m_ov = 0, m_to = 0, m_pdf = 0;
   int m_ie = 0, pk = 0;
   int mm[16];
   int stq[$];  // Mirror of return stack
   logic [5:0] tbl[25] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
      6'h09, 6'h0a, 6'h0b, 6'h11, 6'h12, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c,
      6'h1e, 6'h1f, 6'h20, 6'h21};
   mie_core dut (.*);
   mie_mem_model u_mem (.*);
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input int exp);
      compares++;
      if (seen !== 16'(exp)) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, seen, 16'(exp));
      end
   endtask
   task automatic conclude;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard, far above the thousand or so cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   // Model one op on byte ms, drive it, check the cycle after the taking edge
   task automatic run(input logic [5:0] c, input int imm = 0, addr = 0, bt = 0);
      int a, m, b, s, r, p, ci, we, two, wc, zf, sw;
      a = m_acc; m = mm[ms]; p = m_pc; r = -1; we = 0; two = 0; wc = 0; zf = 0; sw = 0;
      m_pc = (p + 1) % 8192;
      if (c != `MIE_OP_WDT_PRE1 && c != `MIE_OP_WDT_PRE2) pk = 0;
      case (c)
         6'h01, 6'h02, 6'h03, 6'h04, 6'h05: begin  // Sums
            b = (c == `MIE_OP_ADD_X) ? imm : m;
            ci = (c <= `MIE_OP_ADC_M) ? m_c : 0;
            s = a + b + ci;
            m_ac = (a % 16 + b % 16 + ci) > 15;
            m_c = s > 255;
            r = s % 256;
            m_ov = ((a ^ r) & (b ^ r) & 128) != 0;
            we = (c == `MIE_OP_ADC_M || c == `MIE_OP_ADD_M);
            zf = 1;
         end
         6'h06, 6'h07, 6'h08: begin r = a & (c == `MIE_OP_AND_X ? imm : m); we = c == 6'h08;
            zf = 1; end
         6'h09, 6'h0a, 6'h0b: begin r = a | (c == `MIE_OP_OR_X ? imm : m); we = c == 6'h0b;
            zf = 1; end
         6'h16, 6'h17: begin r = 255 - m; we = c == 6'h16; zf = 1; end
         6'h19, 6'h1a: begin r = (m + 255) % 256; we = c == 6'h19; zf = 1; end
         6'h1b, 6'h1c: begin r = (m + 1) % 256; we = c == 6'h1b; zf = 1; end
         6'h21, 6'h22: begin r = (m * 2 + m / 128) % 256; we = c == 6'h21; end
         `MIE_OP_ZFILL: begin r = 0; we = 1; end
         `MIE_OP_ZFILL_BIT: begin r = m & (255 - (1 << bt)); we = 1; end
         `MIE_OP_MOV_AM: r = m;
         `MIE_OP_MOV_AX: r = imm;
         `MIE_OP_MOV_MA: begin r = a; we = 1; end
         `MIE_OP_DAA: begin  // Adjust into byte, carry only set
            s = a + ((a % 16 > 9 || m_ac) ? 6 : 0) + ((a / 16 > 9 || m_c) ? 96 : 0);
            if (s > 255) m_c = 1;
            r = s % 256;
            we = 1;
         end
         `MIE_OP_CALL: begin stq.push_back(m_pc); sw = m_pc; m_pc = addr; two = 1; end
         `MIE_OP_BRANCH: begin m_pc = addr; two = 1; end
         `MIE_OP_PCL_WR: begin m_pc = p - p % 256 + a; two = 1; end
         `MIE_OP_RET, `MIE_OP_RET_X, `MIE_OP_INTERRUPT_EXIT: begin
            m_pc = stq.pop_back();
            two = 2;
            if (c == `MIE_OP_RET_X) r = imm;
            if (c == `MIE_OP_INTERRUPT_EXIT) m_ie = 1;
         end
         `MIE_OP_WDT_KICK: begin m_to = 0; m_pdf = 0; wc = 1; end
         `MIE_OP_WDT_PRE1, `MIE_OP_WDT_PRE2: begin
            if (pk != 0 && pk != c) begin m_to = 0; m_pdf = 0; wc = 1; pk = 0; end
            else pk = c;
         end
         `MIE_OP_PDOWN: begin m_to = 0; m_pdf = 1; wc = 1; two = 3; end
         default: ;
      endcase
      if (zf) m_z = r == 0;
      if (r >= 0 && we) mm[ms] = r;
      else if (r >= 0) m_acc = r;
      sel <= 4'(ms); op_code <= c; op_imm <= 8'(imm); op_addr <= 13'(addr); op_bit <= 3'(bt);
      op_valid <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      chk(acc, m_acc);
      chk(pc, m_pc);
      chk({flag_c, flag_ac, flag_z, flag_ov}, m_c * 8 + m_ac * 4 + m_z * 2 + m_ov);
      chk({flag_to, flag_pdf, irq_en, wdt_clear}, m_to * 8 + m_pdf * 4 + m_ie * 2 + wc);
      chk({mem_we, op_ready, stack_push, stack_pop}, we * 8 + (two == 0) * 4 + (sw != 0) * 2
         + (two == 2));
      if (we) chk(mem_wdata, r);
      if (c == `MIE_OP_CALL) chk(stack_wdata, sw);
      if (c == `MIE_OP_INTERRUPT_EXIT) chk(irq_take, irq_pending);
      @(posedge clk);
   endtask
   task automatic nap;  // Sleep, then wake within a bounded wait
      run(`MIE_OP_PDOWN);
      chk(sys_clk_off, 1);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      #1;
      for (int i = 0; i < 20 && op_ready !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk({sys_clk_off, op_ready}, 1);
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h86bd));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 16; i++) begin  // Load every byte
         ms = i;
         run(`MIE_OP_MOV_AX, $urandom % 256);
         run(`MIE_OP_MOV_MA);
      end
      for (int i = 0; i < 400; i++) begin  // Random single-cycle ops
         ms = $urandom % 16;
         run(tbl[$urandom % 25], $urandom % 256, 0, $urandom % 8);
      end
      run(`MIE_OP_CALL, 0, 13'h1abc);  // Nested calls and returns
      run(`MIE_OP_CALL, 0, 13'h0ff0);
      run(`MIE_OP_BRANCH, 0, 13'h1fff);
      run(`MIE_OP_PCL_WR);
      run(`MIE_OP_RET_X, 8'h5a);
      irq_pending <= 1'b1;
      @(posedge clk);
      run(`MIE_OP_INTERRUPT_EXIT);
      irq_pending <= 1'b0;
      nap();
      run(`MIE_OP_WDT_PRE1);  // Repeats must not act
      run(`MIE_OP_WDT_PRE1);
      run(`MIE_OP_IDLE);
      run(`MIE_OP_WDT_PRE2);
      run(`MIE_OP_WDT_PRE2);
      run(`MIE_OP_IDLE);
      run(`MIE_OP_WDT_PRE1);
      run(`MIE_OP_WDT_PRE2);
      nap();
      run(`MIE_OP_WDT_KICK);
      run(`MIE_OP_RL_A);  // Rotate into acc, byte kept
      conclude();
   end
endmodule
